// >>> hw/pcl_pkg.sv
// Shared constants and types of the port clock, loopback and pin polarity control block.
`default_nettype none

package pcl_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   // Printed offsets are register indices; the byte address is four times the index.
   localparam int unsigned ADDR_W = 9;
   localparam logic [ADDR_W-1:0] IDX_CLOCK_TIMING = 9'h044;
   localparam logic [ADDR_W-1:0] IDX_LOOPBACK_ALARM = 9'h046;
   localparam logic [ADDR_W-1:0] IDX_TX_POLARITY = 9'h04A;
   localparam logic [ADDR_W+1:0] ADDR_CLOCK_TIMING = {IDX_CLOCK_TIMING, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_LOOPBACK_ALARM = {IDX_LOOPBACK_ALARM, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_TX_POLARITY = {IDX_TX_POLARITY, 2'b00};

   // Reset values and writable bit masks; reserved bits read as zero.
   localparam logic [15:0] RST_CLOCK_TIMING = 16'h0000;
   localparam logic [15:0] RST_LOOPBACK_ALARM = 16'h0000;
   localparam logic [15:0] RST_TX_POLARITY = 16'h0000;
   localparam logic [15:0] MASK_CLOCK_TIMING = 16'h3FFF;
   localparam logic [15:0] MASK_LOOPBACK_ALARM = 16'h0FFF;
   localparam logic [15:0] MASK_TX_POLARITY = 16'hDFFF;

   // Avalon response codes.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int unsigned POS_REF_SRC = 6;
   localparam int unsigned POS_REF_LOCAL = 5;
   localparam int unsigned POS_LOOP_TIMING = 4;
   localparam int unsigned POS_ADAPTER_DIS = 3;
   localparam int unsigned POS_RX_FRAMER_TS = 2;
   localparam int unsigned POS_TX_FRAMER_TS = 1;
   localparam int unsigned POS_TX_LINE_TS = 0;
   localparam int unsigned POS_SYS_LOOPBACK = 11;
   localparam int unsigned POS_LOOP_MODE = 8;
   localparam int unsigned POS_ALARM_B = 4;
   localparam int unsigned POS_ALARM_A = 0;

   // Polarity bits that act on pins the device receives; the rest act on driven pins.
   localparam logic [15:0] POL_INPUT_PINS = 16'h0821;
   localparam logic [15:0] POL_OUTPUT_PINS = 16'hD7DE;

   // Loopback mode codes.
   localparam logic [2:0] LBM_NONE = 3'b000;
   localparam logic [2:0] LBM_ANALOG = 3'b001;
   localparam logic [2:0] LBM_LINE = 3'b010;
   localparam logic [2:0] LBM_PAYLOAD = 3'b011;
   localparam logic [2:0] LBM_LINE_DIAG = 3'b110;

   // Alarm order in the status vector, bit 0 first.
   localparam int unsigned NUM_ALARMS = 11;
   // Each select code picks one alarm or an OR of several.
   localparam logic [NUM_ALARMS-1:0] ALARM_MASK [16] = '{
      11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080,
      11'h100, 11'h200, 11'h400, 11'h003, 11'h030, 11'h00F, 11'h470, 11'h7FF};

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {SRC_ADAPTER, SRC_RX_LINE, SRC_TX_PIN} pcl_tx_src_e;

   typedef struct packed {
      logic system_bus;
      logic analog;
      logic line;
      logic payload;
      logic diagnostic;
   } pcl_loopback_s;

   typedef struct packed {
      logic atm_lcd;
      logic plcp_rai;
      logic ds3_idle;
      logic line_los;
      logic atm_ocd;
      logic plcp_lof;
      logic plcp_oof;
      logic rai;
      logic ais;
      logic lof;
      logic oof;
   } pcl_alarm_s;

   typedef struct packed {
      logic rx_framer_input_timed;
      logic tx_framer_input_timed;
      logic tx_line_input_timed;
   } pcl_timing_s;

endpackage : pcl_pkg

`default_nettype wire

// >>> hw/pcl_port_ctrl.sv
// Per-port clock, timing, loopback, alarm pin and transmit pin polarity control.
//
// Contract
// - Reference source code 0X picks receive 8 kHz, 10 line clock, 11 tx framer clock.
// - Reference select 0 uses global 8 kHz reference, 1 uses this port's source.
// - Loop timing clocks transmit from receive line clock or adapter, ignoring tx pin.
// - Adapter disable 0 uses adapter clocks; 1 without loopback uses tx clock pin.
// - Receive framer timing bit picks output clocks at 0, input clocks at 1.
// - Transmit framer timing bit picks output clocks at 0, input clocks at 1.
// - Transmit line timing bit picks output clocks at 0, input clocks at 1.
// - System bus loopback bit returns transmit bus traffic to receive bus.
// - Loop mode 000 none, 001 analog, 010 line, 011 payload loopback.
// - Loop mode 10X and 111 diagnostic only; 110 line plus diagnostic.
// - B select chooses alarm on pin B, driven only when globally enabled.
// - A select chooses alarm on pin A, driven only when globally enabled.
// - Data enable output invert bit flips that output pin polarity.
// - Convergence data invert bit flips the convergence data pin polarity.
// - Shared frame start output invert bit flips that output pin.
// - Shared enable input invert bit flips that input before internal use.
// - Shared overhead data invert bit flips that data pin.
// - Overhead port invert bits flip frame start, enable, data and clock pins.
// - Frame start input and negative rail output invert bits flip those pins.
// - Lowest four bits flip positive rail, line clock, clock out, clock in pins.
//
// Design decision made here: register access over Avalon-MM.
`default_nettype none

module pcl_port_ctrl (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   // Avalon-MM slave.
   input wire logic [pcl_pkg::ADDR_W+1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic [1:0] AVS_RESPONSE,
   output logic AVS_WAITREQUEST,
   // Reference sources.
   input wire logic RX_CL_8K,
   input wire logic RX_LINE_CLOCK_PIN,
   input wire logic TX_FRAMER_CLK,
   input wire logic GLOBAL_8K_REF,
   output logic PORT_REF_8K,
   output logic TRAILER_REF_8K,
   // Transmit clock selection.
   input wire logic TX_CLOCK_INPUT_PIN,
   input wire logic CLOCK_ADAPTER_CLK,
   output pcl_pkg::pcl_tx_src_e TX_CLK_SRC,
   output logic TX_CLK_SEL,
   output pcl_pkg::pcl_timing_s IO_TIMING,
   output pcl_pkg::pcl_loopback_s LOOPBACK,
   // Alarm pins.
   input wire pcl_pkg::pcl_alarm_s ALARM_STATUS,
   input wire logic GLOBAL_PIN_A_EN,
   input wire logic GLOBAL_PIN_B_EN,
   output logic ALARM_PIN_A_OUT,
   output logic ALARM_PIN_A_OE,
   output logic ALARM_PIN_B_OUT,
   output logic ALARM_PIN_B_OE,
   // Transmit side pins, one bit per polarity control bit.
   input wire logic [15:0] TX_CORE_OUT,
   output logic [15:0] TX_PIN_OUT,
   input wire logic [15:0] TX_PIN_IN,
   output logic [15:0] TX_CORE_IN
);

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [15:0] clock_timing;
   logic [15:0] loopback_alarm;
   logic [15:0] tx_polarity;
   logic ack;
   logic [pcl_pkg::ADDR_W+1:0] req_addr;
   logic hit_clock;
   logic hit_loop;
   logic hit_pol;
   logic hit_any;
   logic [15:0] wr_lanes;
   logic [15:0] rd_word;

   // Field views of the stored registers.
   logic [1:0] port_ref_source_sel;
   logic port_ref_use_local;
   logic loop_timing_en;
   logic clock_adapter_disable;
   logic [2:0] loopback_mode_sel;
   logic [3:0] alarm_pin_a_sel;
   logic [3:0] alarm_pin_b_sel;

   assign port_ref_source_sel = clock_timing[pcl_pkg::POS_REF_SRC +: 2];
   assign port_ref_use_local = clock_timing[pcl_pkg::POS_REF_LOCAL];
   assign loop_timing_en = clock_timing[pcl_pkg::POS_LOOP_TIMING];
   assign clock_adapter_disable = clock_timing[pcl_pkg::POS_ADAPTER_DIS];
   assign loopback_mode_sel = loopback_alarm[pcl_pkg::POS_LOOP_MODE +: 3];
   assign alarm_pin_b_sel = loopback_alarm[pcl_pkg::POS_ALARM_B +: 4];
   assign alarm_pin_a_sel = loopback_alarm[pcl_pkg::POS_ALARM_A +: 4];

   // ----------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------
   // Address decode on the word index; the low two byte bits must be zero.
   assign req_addr = AVS_ADDRESS;
   assign hit_clock = (req_addr == pcl_pkg::ADDR_CLOCK_TIMING);
   assign hit_loop = (req_addr == pcl_pkg::ADDR_LOOPBACK_ALARM);
   assign hit_pol = (req_addr == pcl_pkg::ADDR_TX_POLARITY);
   assign hit_any = hit_clock | hit_loop | hit_pol;
   assign wr_lanes = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   // Read data of the addressed register, zero for unmapped addresses.
   always_comb begin
      rd_word = 16'h0000;
      if (hit_clock) begin
         rd_word = clock_timing;
      end else if (hit_loop) begin
         rd_word = loopback_alarm;
      end else if (hit_pol) begin
         rd_word = tx_polarity;
      end
   end

   // Every access waits exactly one cycle; the ack cycle is the one the master samples.
   // A fixed wait keeps read data registered without a combinational path to the bus.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ack <= 1'b0;
      end else if (CE) begin
         ack <= (AVS_READ | AVS_WRITE) & ~ack;
      end
   end

   // Wait request is the inverse of the registered acknowledge.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         AVS_WAITREQUEST <= 1'b1;
      end else if (CE) begin
         AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack);
      end
   end

   // Read data and response are captured as the acknowledge is raised.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         AVS_READDATA <= 32'h0000_0000;
         AVS_RESPONSE <= pcl_pkg::RESP_OKAY;
      end else if (CE) begin
         if ((AVS_READ | AVS_WRITE) & ~ack) begin
            AVS_READDATA <= {16'h0000, (AVS_READ ? rd_word : 16'h0000)};
            AVS_RESPONSE <= hit_any ? pcl_pkg::RESP_OKAY : pcl_pkg::RESP_SLVERR;
         end
      end
   end

   // Writes commit at the edge where wait request is seen low; reserved bits stay zero.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         clock_timing <= pcl_pkg::RST_CLOCK_TIMING;
         loopback_alarm <= pcl_pkg::RST_LOOPBACK_ALARM;
         tx_polarity <= pcl_pkg::RST_TX_POLARITY;
      end else if (CE && ack && AVS_WRITE) begin
         if (hit_clock) begin
            clock_timing <= ((AVS_WRITEDATA[15:0] & wr_lanes) | (clock_timing & ~wr_lanes))
                            & pcl_pkg::MASK_CLOCK_TIMING;
         end
         if (hit_loop) begin
            loopback_alarm <= ((AVS_WRITEDATA[15:0] & wr_lanes) | (loopback_alarm & ~wr_lanes))
                              & pcl_pkg::MASK_LOOPBACK_ALARM;
         end
         if (hit_pol) begin
            tx_polarity <= ((AVS_WRITEDATA[15:0] & wr_lanes) | (tx_polarity & ~wr_lanes))
                           & pcl_pkg::MASK_TX_POLARITY;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reference selection
   // ----------------------------------------------------------------------
   logic next_port_ref;

   // Source codes 0X share one source, so only the high bit splits them.
   always_comb begin
      next_port_ref = RX_CL_8K;
      if (port_ref_source_sel[1]) begin
         next_port_ref = port_ref_source_sel[0] ? TX_FRAMER_CLK : RX_LINE_CLOCK_PIN;
      end
   end

   // The trailer and one-second timer reference follows the local select bit.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         PORT_REF_8K <= 1'b0;
         TRAILER_REF_8K <= 1'b0;
      end else if (CE) begin
         PORT_REF_8K <= next_port_ref;
         TRAILER_REF_8K <= port_ref_use_local ? next_port_ref : GLOBAL_8K_REF;
      end
   end

   // ----------------------------------------------------------------------
   // Loopback decode
   // ----------------------------------------------------------------------
   pcl_pkg::pcl_loopback_s next_loopback;

   // Codes 100, 101 and 111 give diagnostic loopback alone.
   always_comb begin
      next_loopback = '0;
      next_loopback.system_bus = loopback_alarm[pcl_pkg::POS_SYS_LOOPBACK];
      unique case (loopback_mode_sel)
         pcl_pkg::LBM_NONE: begin
         end
         pcl_pkg::LBM_ANALOG: begin
            next_loopback.analog = 1'b1;
         end
         pcl_pkg::LBM_LINE: begin
            next_loopback.line = 1'b1;
         end
         pcl_pkg::LBM_PAYLOAD: begin
            next_loopback.payload = 1'b1;
         end
         pcl_pkg::LBM_LINE_DIAG: begin
            next_loopback.line = 1'b1;
            next_loopback.diagnostic = 1'b1;
         end
         default: begin
            next_loopback.diagnostic = 1'b1;
         end
      endcase
   end

   // Registered loopback controls.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         LOOPBACK <= '0;
      end else if (CE) begin
         LOOPBACK <= next_loopback;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit clock source and pin timing
   // ----------------------------------------------------------------------
   pcl_pkg::pcl_tx_src_e next_tx_src;
   logic any_line_loop;
   logic next_tx_clk;

   // With adapter disable set, a line or analog loopback also retimes transmit from the receive side.
   assign any_line_loop = next_loopback.line | next_loopback.analog;

   // Loop timing never selects the transmit clock pin.
   always_comb begin
      if (loop_timing_en || (any_line_loop && clock_adapter_disable)) begin
         next_tx_src = clock_adapter_disable ? pcl_pkg::SRC_RX_LINE
                                             : pcl_pkg::SRC_ADAPTER;
      end else begin
         next_tx_src = clock_adapter_disable ? pcl_pkg::SRC_TX_PIN
                                             : pcl_pkg::SRC_ADAPTER;
      end
   end

   // Sampled view of the selected clock, taken from the normal-polarity pin input.
   always_comb begin
      unique case (next_tx_src)
         pcl_pkg::SRC_ADAPTER: next_tx_clk = CLOCK_ADAPTER_CLK;
         pcl_pkg::SRC_RX_LINE: next_tx_clk = RX_LINE_CLOCK_PIN;
         pcl_pkg::SRC_TX_PIN: next_tx_clk = TX_CLOCK_INPUT_PIN;
         default: next_tx_clk = 1'b0;
      endcase
   end

   // Registered clock steering and pin timing selects.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         TX_CLK_SRC <= pcl_pkg::SRC_ADAPTER;
         TX_CLK_SEL <= 1'b0;
         IO_TIMING <= '0;
      end else if (CE) begin
         TX_CLK_SRC <= next_tx_src;
         TX_CLK_SEL <= next_tx_clk;
         IO_TIMING.rx_framer_input_timed <= clock_timing[pcl_pkg::POS_RX_FRAMER_TS];
         IO_TIMING.tx_framer_input_timed <= clock_timing[pcl_pkg::POS_TX_FRAMER_TS];
         IO_TIMING.tx_line_input_timed <= clock_timing[pcl_pkg::POS_TX_LINE_TS];
      end
   end

   // ----------------------------------------------------------------------
   // Alarm pins
   // ----------------------------------------------------------------------
   logic next_alarm_a;
   logic next_alarm_b;

   // An OR over the masked alarm vector covers single and grouped codes alike.
   assign next_alarm_a = |(ALARM_STATUS & pcl_pkg::ALARM_MASK[alarm_pin_a_sel]);
   assign next_alarm_b = |(ALARM_STATUS & pcl_pkg::ALARM_MASK[alarm_pin_b_sel]);

   // The pins only drive while the global pin control enables them.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ALARM_PIN_A_OUT <= 1'b0;
         ALARM_PIN_A_OE <= 1'b0;
         ALARM_PIN_B_OUT <= 1'b0;
         ALARM_PIN_B_OE <= 1'b0;
      end else if (CE) begin
         ALARM_PIN_A_OUT <= next_alarm_a & GLOBAL_PIN_A_EN;
         ALARM_PIN_A_OE <= GLOBAL_PIN_A_EN;
         ALARM_PIN_B_OUT <= next_alarm_b & GLOBAL_PIN_B_EN;
         ALARM_PIN_B_OE <= GLOBAL_PIN_B_EN;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit pin polarity
   // ----------------------------------------------------------------------
   // Bit 15 data enable out, 14 data, 12 shared frame start out, 11 shared enable in,
   // 10 shared overhead data, 9..6 overhead port, 5 frame start in, 4 negative rail,
   // 3 positive rail, 2 line clock, 1 clock out, 0 clock in.
   // The flip sits in the flop next to each pin, output or input, so the core never sees inverted
   // polarity; the cost is one cycle of latency through the boundary.
   for (genvar i = 0; i < 16; i++) begin : g_pol
      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            TX_PIN_OUT[i] <= 1'b0;
            TX_CORE_IN[i] <= 1'b0;
         end else if (CE) begin
            TX_PIN_OUT[i] <= pcl_pkg::POL_OUTPUT_PINS[i]
                             & (TX_CORE_OUT[i] ^ tx_polarity[i]);
            TX_CORE_IN[i] <= pcl_pkg::POL_INPUT_PINS[i]
                             & (TX_PIN_IN[i] ^ tx_polarity[i]);
         end
      end
   end

endmodule : pcl_port_ctrl

`default_nettype wire

// >>> bench/pcl_port_ctrl_props.sv
// Concurrent checks on the ports of the port control block.
`default_nettype none

module pcl_port_ctrl_props (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [pcl_pkg::ADDR_W+1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic [1:0] AVS_RESPONSE,
   input wire logic AVS_WAITREQUEST,
   input wire logic GLOBAL_8K_REF,
   input wire logic PORT_REF_8K,
   input wire logic TRAILER_REF_8K,
   input wire pcl_pkg::pcl_tx_src_e TX_CLK_SRC,
   input wire pcl_pkg::pcl_loopback_s LOOPBACK,
   input wire pcl_pkg::pcl_alarm_s ALARM_STATUS,
   input wire logic GLOBAL_PIN_A_EN,
   input wire logic GLOBAL_PIN_B_EN,
   input wire logic ALARM_PIN_A_OUT,
   input wire logic ALARM_PIN_A_OE,
   input wire logic ALARM_PIN_B_OUT,
   input wire logic ALARM_PIN_B_OE,
   input wire logic [15:0] TX_PIN_OUT,
   input wire logic [15:0] TX_CORE_IN
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   // Decoded hit on one of the three registers; anything else must be refused.
   wire logic mapped;
   assign mapped = (AVS_ADDRESS == pcl_pkg::ADDR_CLOCK_TIMING) ||
      (AVS_ADDRESS == pcl_pkg::ADDR_LOOPBACK_ALARM) || (AVS_ADDRESS == pcl_pkg::ADDR_TX_POLARITY);

   // --------------------------------------------------------------------
   // Bus transfer steps
   // --------------------------------------------------------------------
   sequence s_taken;
      CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_ack;
      CE && !AVS_WAITREQUEST;
   endsequence

   a_wait_one: assert property (s_taken |=> !AVS_WAITREQUEST)
      else $error("waitrequest not low one cycle after request");
   a_wait_release: assert property (s_taken ##1 s_ack |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   a_idle_wait: assert property (CE && !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
      else $error("acknowledge without a request");
   a_unmapped_resp: assert property ((s_taken and !mapped) |=>
      AVS_RESPONSE == pcl_pkg::RESP_SLVERR && (AVS_WRITE || AVS_READDATA == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_mapped_okay: assert property ((s_taken and mapped) |=> AVS_RESPONSE == pcl_pkg::RESP_OKAY
      && AVS_READDATA[31:16] == 16'h0000)
      else $error("mapped access answered wrongly");
   a_trailer_src: assert property (CE |=> (TRAILER_REF_8K == $past(GLOBAL_8K_REF)) ||
      (TRAILER_REF_8K == PORT_REF_8K))
      else $error("trailer reference from neither source");
   a_pin_a_enable: assert property (CE |=> ALARM_PIN_A_OE == $past(GLOBAL_PIN_A_EN) &&
      (ALARM_PIN_A_OE || !ALARM_PIN_A_OUT))
      else $error("alarm pin A drive not tied to its enable");
   a_pin_b_enable: assert property (CE |=> ALARM_PIN_B_OE == $past(GLOBAL_PIN_B_EN) &&
      (ALARM_PIN_B_OE || !ALARM_PIN_B_OUT))
      else $error("alarm pin B drive not tied to its enable");
   a_alarm_quiet: assert property (CE && ALARM_STATUS == '0 |=> !ALARM_PIN_A_OUT &&
      !ALARM_PIN_B_OUT)
      else $error("alarm pin high with no alarm");
   a_unused_pins: assert property (((TX_PIN_OUT & ~pcl_pkg::POL_OUTPUT_PINS) == 16'h0000) &&
      ((TX_CORE_IN & ~pcl_pkg::POL_INPUT_PINS) == 16'h0000))
      else $error("pin bit of the wrong direction driven");
   a_reset_state: assert property ($past(SYS_RST) |-> AVS_WAITREQUEST && LOOPBACK == '0 &&
      TX_CLK_SRC == pcl_pkg::SRC_ADAPTER && !PORT_REF_8K)
      else $error("outputs not cleared by reset");
endmodule : pcl_port_ctrl_props

bind pcl_port_ctrl pcl_port_ctrl_props u_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CE(CE),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .GLOBAL_8K_REF(GLOBAL_8K_REF), .PORT_REF_8K(PORT_REF_8K), .TRAILER_REF_8K(TRAILER_REF_8K),
   .TX_CLK_SRC(TX_CLK_SRC), .LOOPBACK(LOOPBACK), .ALARM_STATUS(ALARM_STATUS),
   .GLOBAL_PIN_A_EN(GLOBAL_PIN_A_EN), .GLOBAL_PIN_B_EN(GLOBAL_PIN_B_EN),
   .ALARM_PIN_A_OUT(ALARM_PIN_A_OUT), .ALARM_PIN_A_OE(ALARM_PIN_A_OE),
   .ALARM_PIN_B_OUT(ALARM_PIN_B_OUT), .ALARM_PIN_B_OE(ALARM_PIN_B_OE),
   .TX_PIN_OUT(TX_PIN_OUT), .TX_CORE_IN(TX_CORE_IN));

`default_nettype wire

// >>> bench/pcl_port_ctrl_tb.sv
// Self-checking testbench of the port control block.
`default_nettype none

module pcl_port_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------------------------------------------------------
   // Stimulus and observed signals
   // --------------------------------------------------------------------
   localparam logic [10:0] A_CLK = pcl_pkg::ADDR_CLOCK_TIMING;
   localparam logic [10:0] A_LBK = pcl_pkg::ADDR_LOOPBACK_ALARM;
   localparam logic [10:0] A_POL = pcl_pkg::ADDR_TX_POLARITY;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic CE = 1'b1;
   logic [10:0] AVS_ADDRESS = 11'h000;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [3:0] AVS_BYTEENABLE = 4'h0;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
   logic RX_CL_8K = 1'b0, RX_LINE_CLOCK_PIN = 1'b0, TX_FRAMER_CLK = 1'b0, GLOBAL_8K_REF = 1'b0;
   logic TX_CLOCK_INPUT_PIN = 1'b0, CLOCK_ADAPTER_CLK = 1'b0;
   logic GLOBAL_PIN_A_EN = 1'b0, GLOBAL_PIN_B_EN = 1'b0;
   pcl_pkg::pcl_alarm_s ALARM_STATUS = '0;
   logic [15:0] TX_CORE_OUT = 16'h0000, TX_PIN_IN = 16'h0000;
   logic [31:0] AVS_READDATA;
   logic [1:0] AVS_RESPONSE;
   logic AVS_WAITREQUEST, PORT_REF_8K, TRAILER_REF_8K, TX_CLK_SEL;
   logic ALARM_PIN_A_OUT, ALARM_PIN_A_OE, ALARM_PIN_B_OUT, ALARM_PIN_B_OE;
   pcl_pkg::pcl_tx_src_e TX_CLK_SRC;
   pcl_pkg::pcl_timing_s IO_TIMING;
   pcl_pkg::pcl_loopback_s LOOPBACK;
   logic [15:0] TX_PIN_OUT, TX_CORE_IN;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   pcl_port_ctrl dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_CL_8K(RX_CL_8K), .RX_LINE_CLOCK_PIN(RX_LINE_CLOCK_PIN),
      .TX_FRAMER_CLK(TX_FRAMER_CLK), .GLOBAL_8K_REF(GLOBAL_8K_REF), .PORT_REF_8K(PORT_REF_8K),
      .TRAILER_REF_8K(TRAILER_REF_8K), .TX_CLOCK_INPUT_PIN(TX_CLOCK_INPUT_PIN),
      .CLOCK_ADAPTER_CLK(CLOCK_ADAPTER_CLK), .TX_CLK_SRC(TX_CLK_SRC), .TX_CLK_SEL(TX_CLK_SEL),
      .IO_TIMING(IO_TIMING), .LOOPBACK(LOOPBACK), .ALARM_STATUS(ALARM_STATUS),
      .GLOBAL_PIN_A_EN(GLOBAL_PIN_A_EN), .GLOBAL_PIN_B_EN(GLOBAL_PIN_B_EN),
      .ALARM_PIN_A_OUT(ALARM_PIN_A_OUT), .ALARM_PIN_A_OE(ALARM_PIN_A_OE),
      .ALARM_PIN_B_OUT(ALARM_PIN_B_OUT), .ALARM_PIN_B_OE(ALARM_PIN_B_OE),
      .TX_CORE_OUT(TX_CORE_OUT), .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_IN(TX_PIN_IN),
      .TX_CORE_IN(TX_CORE_IN));

   // Free-running clock; the cycle ceiling cuts a hung bus short.
   always #5 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   // --------------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One transfer; the request stands until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [10:0] a, input logic [15:0] d,
         input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_BYTEENABLE <= be;
      AVS_WRITEDATA <= {16'h0000, d};
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0);
      check(32'(n), 32'h0000_0002);
      q = AVS_READDATA;
      r = AVS_RESPONSE;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask : bus

   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, a, d, 4'h3, q, r);
   endtask : wr

   // Reads a register and compares data and response.
   task automatic rd(input logic [10:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, a, 16'h0000, 4'h3, q, r);
      check(q, exp);
      check(32'(r), 32'(er));
   endtask : rd

   // Decoded outputs follow a register or input change one edge later; settle waits two edges.
   task automatic settle();
      repeat (2) @(posedge SYS_CLK);
   endtask : settle

   // --------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------
   task automatic t_regs();
      rd(A_CLK, 32'h0000_0000, 2'b00);
      rd(A_LBK, 32'h0000_0000, 2'b00);
      rd(A_POL, 32'h0000_0000, 2'b00);
      check(32'({LOOPBACK, IO_TIMING, TX_CLK_SRC}), 32'h0000_0000);
      wr(A_CLK, 16'hFFFF);
      wr(A_LBK, 16'hFFFF);
      wr(A_POL, 16'hFFFF);
      rd(A_CLK, 32'h0000_3FFF, 2'b00);
      rd(A_LBK, 32'h0000_0FFF, 2'b00);
      rd(A_POL, 32'h0000_DFFF, 2'b00);
      rd(11'h7FC, 32'h0000_0000, 2'b10);
      $display("t_regs done");
   endtask : t_regs

   // Decoded controls, reference choice, alarm pin and pin polarity after the full writes.
   task automatic t_ctrl();
      @(posedge SYS_CLK);
      TX_FRAMER_CLK <= 1'b1;
      GLOBAL_8K_REF <= 1'b1;
      ALARM_STATUS <= 11'h001;
      GLOBAL_PIN_A_EN <= 1'b1;
      settle();
      check(32'({PORT_REF_8K, TRAILER_REF_8K}), 32'h0000_0003);
      check(32'({TX_CLK_SRC, IO_TIMING}), 32'h0000_000F);
      check({TX_PIN_OUT, TX_CORE_IN}, 32'hD7DE_0821);
      wr(A_LBK, 16'h0E00);
      settle();
      check(32'(LOOPBACK), 32'h0000_0015);
      check(32'({ALARM_PIN_A_OUT, ALARM_PIN_A_OE}), 32'h0000_0003);
      wr(A_LBK, 16'h0100);
      wr(A_CLK, 16'h0008);
      settle();
      check(32'({LOOPBACK, TX_CLK_SRC}), 32'h0000_0021);
      wr(A_LBK, 16'h0000);
      settle();
      check(32'({TX_CLK_SRC, TRAILER_REF_8K}), 32'h0000_0005);
      $display("t_ctrl done");
   endtask : t_ctrl

   // Reset is held for twelve edges, then the scenarios run in order.
   initial begin
      repeat (12) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      t_regs();
      t_ctrl();
      finish_test();
   end

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
endmodule : pcl_port_ctrl_tb

`default_nettype wire
